// *** rtl/adr_cfg_regs.sv ***
// Configuration register bank top: control port, decode, channel 6, mute, volume
// Notes on behaviour
// - Ratio code selects x4, x2 or pass-through.
// - Bass enable feeds channel 6 from mixer.
// - Max power correction bit, reset one, enables.
// - Correction active only in mode 00 or 10.
// - Bypass bit skips biquad and tone stages.
// - Zero-detect mute enable, reset one, gates muting.
// - 2048 zero samples mute that channel alone.
// - Format field picks I2S, left or right justified.
// - Bit order bit picks MSB or LSB first.
// - Zero-cross bit defers volume to zero crossings.
// - Bit 7 picks anti-clip or compression limiting.
// - Compression thresholds track volume, anti-clip constant.
// - Output mode 00 fixed, 10 full, others reserved.
`timescale 1ns/1ps
module adr_cfg_regs (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic                  scl_i,
	input  wire logic                  sda_i,
	input  wire logic                  sa_i,
	output logic                       sda_o,
	output logic                       sda_oe,
	input  wire logic                  smp_vld,
	input  wire adr_pkg::adr_smp_arr_t map_smp,
	input  wire logic [adr_pkg::SW-1:0] mix_smp,
	input  wire logic                  vol_req,
	input  wire logic [2:0]            vol_req_ch,
	input  wire logic [7:0]            vol_req_val,
	input  wire adr_pkg::adr_lim_arr_t lim_base,
	output adr_pkg::adr_cfg_t          cfg,
	output logic [adr_pkg::SW-1:0]     ch6_smp,
	output logic [adr_pkg::NCH-1:0]    ch_mute,
	output adr_pkg::adr_vol_arr_t      vol_applied,
	output adr_pkg::adr_lim_arr_t      lim_thresh
);
	import adr_pkg::*;

	// ==========================================================
	// Decode functions
	function automatic adr_interp_t dec_interp(input logic [1:0] code);
		adr_interp_t r;
		r      = '0;
		r.x4   = (code == RATIO_X4);
		r.x2   = (code == RATIO_X2);
		r.pass = (code == RATIO_PASS);
		// Code 11 is undefined; flag it and select nothing
		r.bad  = (code == 2'h3);
		return r;
	endfunction

	function automatic adr_fmt_t dec_fmt(input logic [2:0] code, input logic lsbf);
		adr_fmt_t r;
		r           = '0;
		r.lsb_first = lsbf;
		case (code)
			FMT_I2S:  r.i2s = 1'b1;
			FMT_LJ:   r.lj  = 1'b1;
			FMT_RJ16: r     = '{1'b0, 1'b0, 1'b1, 5'h10, lsbf, 1'b0};
			FMT_RJ18: r     = '{1'b0, 1'b0, 1'b1, 5'h12, lsbf, 1'b0};
			FMT_RJ20: r     = '{1'b0, 1'b0, 1'b1, 5'h14, lsbf, 1'b0};
			FMT_RJ24: r     = '{1'b0, 1'b0, 1'b1, 5'h18, lsbf, 1'b0};
			default:  r.bad = 1'b1;
		endcase
		return r;
	endfunction

	// ==========================================================
	// State
	typedef struct packed {
		logic [1:0]            sa_m;
		logic [7:0]            cfg_a;
		logic [7:0]            cfg_b;
		logic [7:0]            cfg_c;
		adr_cfg_t              cfg;
		logic [SW-1:0]         ch6;
		adr_vol_arr_t          vol;
		adr_vol_arr_t          pend_val;
		logic [NCH-1:0]        pend;
		logic [NCH-1:0]        prev_neg;
		adr_lim_arr_t          lim;
	} adr_top_st_t;

	adr_top_st_t    s_r;
	adr_top_st_t    s_nxt;
	adr_wr_t        wr;
	logic [7:0]     rd_addr;
	logic [7:0]     rd_data;
	logic [6:0]     dev_addr;
	logic [NCH-1:0] zc;
	logic [8:0]     lim_sum;

	// ==========================================================
	// Control port
	adr_i2c_slave adr_i2c_slave_inst (
		.clk      (clk),
		.nrst     (nrst),
		.scl_i    (scl_i),
		.sda_i    (sda_i),
		.dev_addr (dev_addr),
		.rd_data  (rd_data),
		.sda_o    (sda_o),
		.sda_oe   (sda_oe),
		.rd_addr  (rd_addr),
		.wr       (wr)
	);

	// ==========================================================
	// Zero detect, one per processing channel after mapping
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_zd
			adr_zero_det adr_zero_det_inst (
				.clk     (clk),
				.nrst    (nrst),
				.en      (s_r.cfg.zero_detect_mute_en),
				.smp_vld (smp_vld),
				.smp     (map_smp[g]),
				.mute    (ch_mute[g])
			);
		end
	endgenerate

	// ==========================================================
	// Read mux and next state
	always_comb begin
		dev_addr = s_r.sa_m[1] ? I2C_DEV_SA1 : I2C_DEV_SA0;
		case (rd_addr)
			ADDR_CFG_A: rd_data = s_r.cfg_a;
			ADDR_CFG_B: rd_data = s_r.cfg_b;
			ADDR_CFG_C: rd_data = s_r.cfg_c;
			default:    rd_data = 8'h00;
		endcase
		// Zero crossing: sign flip or exact zero on this sample
		for (int i = 0; i < NCH; i++) begin
			zc[i] = smp_vld &&
				((map_smp[i][SW-1] != s_r.prev_neg[i]) || (map_smp[i] == '0));
		end

		s_nxt      = s_r;
		s_nxt.sa_m = {s_r.sa_m[0], sa_i};
		if (wr.stb) begin
			case (wr.addr)
				ADDR_CFG_A: s_nxt.cfg_a = wr.data;
				ADDR_CFG_B: s_nxt.cfg_b = wr.data;
				ADDR_CFG_C: s_nxt.cfg_c = (wr.data & CFG_C_WMASK) |
					(RST_CFG_C & ~CFG_C_WMASK);
				default: begin
				end
			endcase
		end

		// Registered decode of the stored fields
		s_nxt.cfg.interp       = dec_interp(s_r.cfg_a[A_RATIO_LSB +: 2]);
		s_nxt.cfg.bass_mgmt_en = s_r.cfg_a[A_BASS_EN];
		s_nxt.cfg.fixed_comp   = (s_r.cfg_c[C_PMODE_LSB +: 2] == PMODE_FIXED);
		s_nxt.cfg.full_power   = (s_r.cfg_c[C_PMODE_LSB +: 2] == PMODE_FULL);
		s_nxt.cfg.om_reserved  = s_r.cfg_c[C_PMODE_LSB];
		s_nxt.cfg.max_power_corr_en = s_r.cfg_a[A_CORR_EN] &&
			!s_r.cfg_c[C_PMODE_LSB];
		s_nxt.cfg.dsp_bypass          = s_r.cfg_b[B_BYPASS];
		s_nxt.cfg.zero_detect_mute_en = s_r.cfg_b[B_ZMUTE_EN];
		s_nxt.cfg.fmt = dec_fmt(s_r.cfg_b[B_FMT_LSB +: 3], s_r.cfg_b[B_LSBF]);
		s_nxt.cfg.zero_cross_vol_en     = s_r.cfg_b[B_ZCROSS];
		s_nxt.cfg.limiter_compress_mode = s_r.cfg_b[B_COMPRESS];
		s_nxt.cfg.highpass_bypass       = s_r.cfg_c[C_HP_BYPASS];

		// Channel 6 source
		s_nxt.ch6 = s_r.cfg.bass_mgmt_en ? mix_smp : map_smp[5];

		// Volume update, immediate or deferred to a zero crossing
		for (int i = 0; i < NCH; i++) begin
			if (smp_vld) begin
				s_nxt.prev_neg[i] = map_smp[i][SW-1];
			end
			if (zc[i] && s_r.pend[i]) begin
				s_nxt.vol[i]  = s_r.pend_val[i];
				s_nxt.pend[i] = 1'b0;
			end
			if (vol_req && (vol_req_ch == i[2:0])) begin
				if (s_r.cfg.zero_cross_vol_en) begin
					s_nxt.pend[i]     = 1'b1;
					s_nxt.pend_val[i] = vol_req_val;
				end else begin
					s_nxt.vol[i]  = vol_req_val;
					s_nxt.pend[i] = 1'b0;
				end
			end
		end
		// Turning deferral off flushes anything still waiting
		if (!s_r.cfg.zero_cross_vol_en) begin
			for (int i = 0; i < NCH; i++) begin
				if (s_r.pend[i]) begin
					s_nxt.vol[i]  = s_r.pend_val[i];
					s_nxt.pend[i] = 1'b0;
				end
			end
		end

		// Limiter thresholds: compression shifts by channel 1 attenuation
		lim_sum = '0;
		for (int j = 0; j < 2; j++) begin
			lim_sum = {1'b0, lim_base[j]} + {1'b0, s_r.vol[0]};
			if (s_r.cfg.limiter_compress_mode) begin
				s_nxt.lim[j] = lim_sum[8] ? 8'hFF : lim_sum[7:0];
			end else begin
				s_nxt.lim[j] = lim_base[j];
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_r       <= '0;
			s_r.cfg_a <= RST_CFG_A;
			s_r.cfg_b <= RST_CFG_B;
			s_r.cfg_c <= RST_CFG_C;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign cfg         = s_r.cfg;
	assign ch6_smp     = s_r.ch6;
	assign vol_applied = s_r.vol;
	assign lim_thresh  = s_r.lim;

endmodule // adr_cfg_regs

// *** rtl/adr_i2c_slave.sv ***
// Two-wire control port slave: byte writes, auto-increment, reads
`timescale 1ns/1ps
module adr_i2c_slave (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             scl_i,
	input  wire logic             sda_i,
	input  wire logic [6:0]       dev_addr,
	input  wire logic [7:0]       rd_data,
	output logic                  sda_o,
	output logic                  sda_oe,
	output logic [7:0]            rd_addr,
	output adr_pkg::adr_wr_t      wr
);
	import adr_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_ACK_A, S_REG, S_ACK_R, S_WDATA, S_RDATA, S_RACK
	} adr_i2c_state_t;

	typedef struct packed {
		logic [1:0]     scl_m;
		logic [1:0]     sda_m;
		logic           scl_p;
		logic           sda_p;
		adr_i2c_state_t st;
		logic [7:0]     sh;
		logic [3:0]     cnt;
		logic [7:0]     ptr;
		logic           rw;
		logic           oe;
		adr_wr_t        wr;
	} adr_i2c_st_t;

	adr_i2c_st_t s_r;
	adr_i2c_st_t s_nxt;
	logic        scl;
	logic        sda;
	logic        rise;
	logic        fall;

	always_comb begin
		scl    = s_r.scl_m[1];
		sda    = s_r.sda_m[1];
		rise   = scl & !s_r.scl_p;
		fall   = !scl & s_r.scl_p;
		s_nxt  = s_r;
		s_nxt.scl_m  = {s_r.scl_m[0], scl_i};
		s_nxt.sda_m  = {s_r.sda_m[0], sda_i};
		s_nxt.scl_p  = scl;
		s_nxt.sda_p  = sda;
		s_nxt.wr.stb = 1'b0;
		if (scl && s_r.scl_p && s_r.sda_p && !sda) begin
			s_nxt.st  = S_ADDR;
			s_nxt.cnt = '0;
			s_nxt.oe  = 1'b0;
		end else if (scl && s_r.scl_p && !s_r.sda_p && sda) begin
			s_nxt.st = S_IDLE;
			s_nxt.oe = 1'b0;
		end else if (rise) begin
			case (s_r.st)
				S_ADDR, S_REG, S_WDATA: begin
					s_nxt.sh  = {s_r.sh[6:0], sda};
					s_nxt.cnt = s_r.cnt + 4'h1;
				end
				S_RACK: begin
					if (sda) begin
						s_nxt.st = S_IDLE;
					end
				end
				default: begin
				end
			endcase
		end else if (fall) begin
			case (s_r.st)
				S_ADDR: begin
					if (s_r.cnt == 4'h8) begin
						if (s_r.sh[7:1] == dev_addr) begin
							s_nxt.st = S_ACK_A;
							s_nxt.oe = 1'b1;
							s_nxt.rw = s_r.sh[0];
						end else begin
							s_nxt.st = S_IDLE;
						end
					end
				end
				S_ACK_A, S_RACK: begin
					s_nxt.cnt = '0;
					if (s_r.rw) begin
						s_nxt.st = S_RDATA;
						s_nxt.sh = rd_data;
						s_nxt.oe = !rd_data[7];
						s_nxt.ptr = s_r.ptr + 8'h01;
					end else begin
						s_nxt.st = S_REG;
						s_nxt.oe = 1'b0;
					end
				end
				S_REG: begin
					if (s_r.cnt == 4'h8) begin
						s_nxt.ptr = s_r.sh;
						s_nxt.st  = S_ACK_R;
						s_nxt.oe  = 1'b1;
					end
				end
				S_ACK_R: begin
					s_nxt.st  = S_WDATA;
					s_nxt.cnt = '0;
					s_nxt.oe  = 1'b0;
				end
				S_WDATA: begin
					if (s_r.cnt == 4'h8) begin
						s_nxt.wr  = '{stb: 1'b1, addr: s_r.ptr, data: s_r.sh};
						s_nxt.ptr = s_r.ptr + 8'h01;
						s_nxt.st  = S_ACK_R;
						s_nxt.oe  = 1'b1;
					end
				end
				S_RDATA: begin
					s_nxt.cnt = s_r.cnt + 4'h1;
					s_nxt.sh  = {s_r.sh[6:0], 1'b0};
					s_nxt.oe  = !s_r.sh[6];
					if (s_r.cnt == 4'h7) begin
						s_nxt.st = S_RACK;
						s_nxt.oe = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_r       <= '0;
			s_r.scl_m <= 2'h3;
			s_r.sda_m <= 2'h3;
			s_r.scl_p <= 1'b1;
			s_r.sda_p <= 1'b1;
			s_r.st    <= S_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Open drain: only ever pulls low
	assign sda_o   = 1'b0;
	assign sda_oe  = s_r.oe;
	assign rd_addr = s_r.ptr;
	assign wr      = s_r.wr;

endmodule // adr_i2c_slave

// *** rtl/adr_pkg.sv ***
// Package: constants, codes and carrier types of the audio config register bank
package adr_pkg;

	// ==========================================================
	// Sizes
	localparam int NCH  = 8;
	localparam int SW   = 24;
	localparam int ZD_W = 11;

	// ==========================================================
	// Register offsets and reset values
	localparam logic [7:0] ADDR_CFG_A  = 8'h00;
	localparam logic [7:0] ADDR_CFG_B  = 8'h01;
	localparam logic [7:0] ADDR_CFG_C  = 8'h02;
	localparam logic [7:0] RST_CFG_A   = 8'h83;
	localparam logic [7:0] RST_CFG_B   = 8'h42;
	localparam logic [7:0] RST_CFG_C   = 8'h7C;
	localparam logic [7:0] CFG_C_WMASK = 8'h83;

	// ==========================================================
	// Field positions
	localparam int A_RATIO_LSB = 3;
	localparam int A_BASS_EN   = 5;
	localparam int A_CORR_EN   = 7;
	localparam int B_BYPASS    = 0;
	localparam int B_ZMUTE_EN  = 1;
	localparam int B_FMT_LSB   = 2;
	localparam int B_LSBF      = 5;
	localparam int B_ZCROSS    = 6;
	localparam int B_COMPRESS  = 7;
	localparam int C_PMODE_LSB = 0;
	localparam int C_HP_BYPASS = 7;

	// ==========================================================
	// Codes
	localparam logic [1:0] RATIO_X4    = 2'h0;
	localparam logic [1:0] RATIO_X2    = 2'h1;
	localparam logic [1:0] RATIO_PASS  = 2'h2;
	localparam logic [2:0] FMT_I2S     = 3'h0;
	localparam logic [2:0] FMT_LJ      = 3'h1;
	localparam logic [2:0] FMT_RJ16    = 3'h2;
	localparam logic [2:0] FMT_RJ18    = 3'h3;
	localparam logic [2:0] FMT_RJ20    = 3'h4;
	localparam logic [2:0] FMT_RJ24    = 3'h5;
	localparam logic [1:0] PMODE_FIXED = 2'h0;
	localparam logic [1:0] PMODE_FULL  = 2'h2;
	localparam logic [6:0] I2C_DEV_SA0 = 7'h18;
	localparam logic [6:0] I2C_DEV_SA1 = 7'h19;
	localparam logic [ZD_W-1:0] ZD_LAST = 11'h7FF;

	// ==========================================================
	// Carrier types
	typedef logic [NCH-1:0][SW-1:0] adr_smp_arr_t;
	typedef logic [NCH-1:0][7:0]    adr_vol_arr_t;
	typedef logic [1:0][7:0]        adr_lim_arr_t;

	typedef struct packed {
		logic x4;
		logic x2;
		logic pass;
		logic bad;
	} adr_interp_t;

	typedef struct packed {
		logic       i2s;
		logic       lj;
		logic       rj;
		logic [4:0] rj_bits;
		logic       lsb_first;
		logic       bad;
	} adr_fmt_t;

	typedef struct packed {
		adr_interp_t interp;
		logic        bass_mgmt_en;
		logic        max_power_corr_en;
		logic        dsp_bypass;
		logic        zero_detect_mute_en;
		adr_fmt_t    fmt;
		logic        zero_cross_vol_en;
		logic        limiter_compress_mode;
		logic        fixed_comp;
		logic        full_power;
		logic        om_reserved;
		logic        highpass_bypass;
	} adr_cfg_t;

	typedef struct packed {
		logic       stb;
		logic [7:0] addr;
		logic [7:0] data;
	} adr_wr_t;

endpackage

// *** rtl/adr_zero_det.sv ***
// Per-channel zero-run detector driving the automatic mute
`timescale 1ns/1ps
module adr_zero_det (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic                  en,
	input  wire logic                  smp_vld,
	input  wire logic [adr_pkg::SW-1:0] smp,
	output logic                       mute
);
	import adr_pkg::*;

	typedef struct packed {
		logic [ZD_W-1:0] cnt;
		logic            mute;
	} adr_zd_st_t;

	adr_zd_st_t st_r;
	adr_zd_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (smp_vld) begin
			if (smp == '0) begin
				if (st_r.cnt == ZD_LAST) begin
					st_nxt.mute = 1'b1;
				end else begin
					st_nxt.cnt = st_r.cnt + 11'h001;
				end
			end else begin
				st_nxt.cnt  = '0;
				st_nxt.mute = 1'b0;
			end
		end
		// Disabling releases the mute at once; the run count keeps going
		if (!en) begin
			st_nxt.mute = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign mute = st_r.mute;

endmodule // adr_zero_det

// *** verification/adr_cfg_regs_asserts.sv ***
// Checker: port-level properties of the audio config register bank
`timescale 1ns/1ps
module adr_cfg_regs_asserts (
	input wire logic                    clk,
	input wire logic                    nrst,
	input wire logic                    smp_vld,
	input wire adr_pkg::adr_smp_arr_t   map_smp,
	input wire logic [adr_pkg::SW-1:0]  mix_smp,
	input wire logic                    vol_req,
	input wire logic [2:0]              vol_req_ch,
	input wire logic [7:0]              vol_req_val,
	input wire adr_pkg::adr_lim_arr_t   lim_base,
	input wire adr_pkg::adr_cfg_t       cfg,
	input wire logic [adr_pkg::SW-1:0]  ch6_smp,
	input wire logic [adr_pkg::NCH-1:0] ch_mute,
	input wire adr_pkg::adr_vol_arr_t   vol_applied,
	input wire adr_pkg::adr_lim_arr_t   lim_thresh
);
	import adr_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// Decode
	property p_interp;
		$past(nrst, 2) |-> $onehot(cfg.interp);
	endproperty
	a_interp: assert property (p_interp) else $error("interp not one-hot");
	property p_mpc;
		cfg.max_power_corr_en |-> !cfg.om_reserved && (cfg.fixed_comp || cfg.full_power);
	endproperty
	a_mpc: assert property (p_mpc) else $error("correction in reserved mode");
	property p_fmt;
		cfg.fmt.rj |-> !cfg.fmt.i2s && !cfg.fmt.lj
			&& cfg.fmt.rj_bits inside {5'h10, 5'h12, 5'h14, 5'h18};
	endproperty
	a_fmt: assert property (p_fmt) else $error("bad format decode");
	// ==========================================================
	// Datapath side
	property p_ch6;
		(smp_vld && cfg.bass_mgmt_en) ##1 cfg.bass_mgmt_en |-> ch6_smp == $past(mix_smp);
	endproperty
	a_ch6: assert property (p_ch6) else $error("channel 6 not from mixer");
	property p_mute_set;
		(ch_mute & ~$past(ch_mute)) != 8'h00 |-> $past(smp_vld);
	endproperty
	a_mute_set: assert property (p_mute_set) else $error("mute without sample");
	property p_mute_clr;
		smp_vld && map_smp[0] != 24'h000000 |=> !ch_mute[0];
	endproperty
	a_mute_clr: assert property (p_mute_clr) else $error("mute kept on data");
	property p_zde;
		!cfg.zero_detect_mute_en [*2] |-> ch_mute == 8'h00;
	endproperty
	a_zde: assert property (p_zde) else $error("mute while disabled");
	property p_vol_imm;
		(vol_req && !cfg.zero_cross_vol_en) ##1 !cfg.zero_cross_vol_en
			|-> vol_applied[$past(vol_req_ch)] == $past(vol_req_val);
	endproperty
	a_vol_imm: assert property (p_vol_imm) else $error("volume not immediate");
	property p_vol_zc;
		(!smp_vld && !vol_req && cfg.zero_cross_vol_en) ##1 cfg.zero_cross_vol_en
			|-> $stable(vol_applied);
	endproperty
	a_vol_zc: assert property (p_vol_zc) else $error("volume moved off sample");
	property p_lim;
		($past(nrst) && !cfg.limiter_compress_mode) ##1 !cfg.limiter_compress_mode
			|-> lim_thresh == $past(lim_base);
	endproperty
	a_lim: assert property (p_lim) else $error("anti-clip threshold moved");
endmodule // adr_cfg_regs_asserts

bind adr_cfg_regs adr_cfg_regs_asserts adr_cfg_regs_asserts_inst (
	.clk(clk), .nrst(nrst), .smp_vld(smp_vld), .map_smp(map_smp), .mix_smp(mix_smp),
	.vol_req(vol_req), .vol_req_ch(vol_req_ch), .vol_req_val(vol_req_val),
	.lim_base(lim_base), .cfg(cfg), .ch6_smp(ch6_smp), .ch_mute(ch_mute),
	.vol_applied(vol_applied), .lim_thresh(lim_thresh)
);

// *** verification/test_adr_cfg_regs.sv ***
// Testbench: control port, decode, channel 6, zero mute, volume, limiter
`timescale 1ns/1ps
`define CHK(g, e) begin got_q.push_back(32'(g)); exp_q.push_back(32'(e)); end
module test_adr_cfg_regs;
	import adr_pkg::*;
	// ==========================================================
	// Signals
	logic           clk     = 1'b0;
	logic           nrst    = 1'b0;
	logic           scl     = 1'b1;
	logic           sda_m   = 1'b1;
	logic           sa      = 1'b0;
	logic           smp_vld = 1'b0;
	logic           vol_req = 1'b0;
	logic [2:0]     vch     = 3'h0;
	logic [7:0]     vval    = 8'h00;
	logic [SW-1:0]  mix     = '0;
	adr_smp_arr_t   map     = '0;
	adr_lim_arr_t   lbase   = '0;
	logic [6:0]     dev     = I2C_DEV_SA0;
	logic [4:0]     rjb [6] = '{5'h00, 5'h00, 5'h10, 5'h12, 5'h14, 5'h18};
	logic           sda_o;
	logic           sda_oe;
	adr_cfg_t       cf;
	logic [SW-1:0]  ch6;
	logic [NCH-1:0] mute;
	adr_vol_arr_t   vol;
	adr_lim_arr_t   lth;
	logic [31:0]    got_q[$];
	logic [31:0]    exp_q[$];
	logic           ak;
	int             error_cnt    = 0;
	int             total_checks = 0;
	int             cyc          = 0;
	// Open drain: any low driver wins
	wire            sda_w = sda_m & ~(sda_oe & ~sda_o);

	adr_cfg_regs adr_cfg_regs_inst (
		.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda_w), .sa_i(sa),
		.sda_o(sda_o), .sda_oe(sda_oe), .smp_vld(smp_vld), .map_smp(map),
		.mix_smp(mix), .vol_req(vol_req), .vol_req_ch(vch), .vol_req_val(vval),
		.lim_base(lbase), .cfg(cf), .ch6_smp(ch6), .ch_mute(mute),
		.vol_applied(vol), .lim_thresh(lth)
	);

	always #20 clk = ~clk;

	// ==========================================================
	// Scoreboard and run control
	always begin
		wait (got_q.size() > 0);
		total_checks++;
		if (got_q[0] !== exp_q[0]) begin
			error_cnt++;
			$display("mismatch %0t got %h exp %h", $time, got_q[0], exp_q[0]);
		end
		void'(got_q.pop_front());
		void'(exp_q.pop_front());
	end

	task automatic wrap_up();
		#1;
		if (error_cnt == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Whole run needs about 27k cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			wrap_up();
		end
	end

	// ==========================================================
	// Drivers
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Slow bit time: slave needs 8+ cycles per level
	task automatic bit_x(input logic b, output logic r);
		sda_m <= b;
		w(10);
		scl <= 1'b1;
		w(5);
		r = sda_w;
		w(5);
		scl <= 1'b0;
	endtask

	// s=1 start (or repeated start), s=0 stop
	task automatic cond(input logic s);
		sda_m <= s;
		w(10);
		scl <= 1'b1;
		w(10);
		sda_m <= ~s;
		w(10);
		scl <= ~s;
	endtask

	task automatic byte_x(input logic [7:0] d, output logic a);
		for (int i = 7; i >= 0; i--) bit_x(d[i], a);
		bit_x(1'b1, a);
	endtask

	task automatic xfer(input logic [7:0] a, input logic rd, input logic [7:0] dw,
		output logic [7:0] dr);
		dr = 8'h00;
		cond(1'b1);
		byte_x({dev, 1'b0}, ak);
		byte_x(a, ak);
		if (rd) begin
			cond(1'b1);
			byte_x({dev, 1'b1}, ak);
			for (int i = 7; i >= 0; i--) bit_x(1'b1, dr[i]);
			bit_x(1'b1, ak);
		end else
			byte_x(dw, ak);
		cond(1'b0);
	endtask

	task automatic smp(input adr_smp_arr_t m);
		@(posedge clk);
		map <= m;
		smp_vld <= 1'b1;
		@(posedge clk);
		smp_vld <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic vq(input logic [2:0] ch, input logic [7:0] v);
		@(posedge clk);
		vch <= ch;
		vval <= v;
		vol_req <= 1'b1;
		@(posedge clk);
		vol_req <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	function automatic adr_smp_arr_t rs(input logic [SW-1:0] c0);
		adr_smp_arr_t r;
		for (int c = 0; c < NCH; c++) r[c] = 24'($urandom) | 24'h000001;
		r[0] = c0;
		return r;
	endfunction

	// ==========================================================
	// Main sequence
	initial begin
		logic [7:0] d;
		logic [7:0] b;
		void'($urandom(62240));
		w(6);
		nrst <= 1'b1;
		w(6);
		xfer(ADDR_CFG_A, 1'b1, 8'h00, d);
		`CHK(d, RST_CFG_A)
		xfer(ADDR_CFG_B, 1'b1, 8'h00, d);
		`CHK(d, RST_CFG_B)
		xfer(ADDR_CFG_C, 1'b1, 8'h00, d);
		`CHK(d, RST_CFG_C)
		`CHK({cf.max_power_corr_en, cf.zero_detect_mute_en, cf.zero_cross_vol_en}, 3'h7)
		// Only the three defined ratio codes are written
		for (int i = 0; i < 3; i++) begin
			b = 8'(8'h80 | (i << A_RATIO_LSB) | ((i % 2) << A_BASS_EN));
			xfer(ADDR_CFG_A, 1'b0, b, d);
			xfer(ADDR_CFG_A, 1'b1, 8'h00, d);
			`CHK(d, b)
			`CHK(cf.interp, {i == 0, i == 1, i == 2, 1'b0})
			mix <= 24'($urandom);
			smp(rs(24'h000001));
			`CHK(ch6, (i % 2) ? mix : map[5])
		end
		for (int i = 0; i < 4; i++) begin
			b = {1'($urandom), 5'h00, 2'(i)};
			xfer(ADDR_CFG_C, 1'b0, b, d);
			xfer(ADDR_CFG_C, 1'b1, 8'h00, d);
			`CHK(d, (b & CFG_C_WMASK) | (RST_CFG_C & ~CFG_C_WMASK))
			`CHK({cf.max_power_corr_en, cf.fixed_comp, cf.full_power}, {i % 2 == 0, i == 0, i == 2})
			`CHK({cf.om_reserved, cf.highpass_bypass}, {i % 2 == 1, b[C_HP_BYPASS]})
		end
		for (int i = 0; i < 6; i++) begin
			b = {3'($urandom), 3'(i), 1'b1, 1'($urandom)};
			xfer(ADDR_CFG_B, 1'b0, b, d);
			`CHK({cf.fmt.i2s, cf.fmt.lj, cf.fmt.rj, cf.fmt.bad}, {i == 0, i == 1, i > 1, 1'b0})
			`CHK(cf.fmt.rj ? cf.fmt.rj_bits : 5'h00, rjb[i])
			`CHK({cf.fmt.lsb_first, cf.dsp_bypass}, {b[B_LSBF], b[B_BYPASS]})
			`CHK({cf.limiter_compress_mode, cf.zero_cross_vol_en}, b[7:6])
		end
		// Offsets past the bank: write dropped, read zero
		xfer(8'h03, 1'b0, 8'hA5, d);
		xfer(8'h03, 1'b1, 8'h00, d);
		`CHK(d, 8'h00)
		xfer(ADDR_CFG_B, 1'b0, 8'h02, d);
		for (int n = 1; n <= 2048; n++) begin
			smp(rs(24'h000000));
			if (n >= 2047) `CHK(mute, n == 2048)
		end
		xfer(ADDR_CFG_B, 1'b0, 8'h00, d);
		smp(rs(24'h000000));
		`CHK(mute, 8'h00)
		lbase <= {8'h10, 8'hF0};
		vq(3'h3, 8'h5A);
		`CHK(vol[3], 8'h5A)
		vq(3'h0, 8'h20);
		`CHK(lth, {8'h10, 8'hF0})
		xfer(ADDR_CFG_B, 1'b0, 8'hC0, d);
		`CHK(lth, {8'h30, 8'hFF})
		// Pending volume waits for a sign change
		vq(3'h0, 8'h40);
		smp(rs(24'h000100));
		`CHK(vol[0], 8'h20)
		smp(rs(24'h800100));
		w(2);
		`CHK({vol[0], lth}, {8'h40, 8'h50, 8'hFF})
		// Strap moves the slave address; old one gets no answer
		sa <= 1'b1;
		w(4);
		xfer(ADDR_CFG_A, 1'b1, 8'h00, d);
		`CHK(d, 8'hFF)
		dev = I2C_DEV_SA1;
		xfer(ADDR_CFG_A, 1'b1, 8'h00, d);
		`CHK(d, 8'h90)
		wrap_up();
	end
endmodule // test_adr_cfg_regs
